// ---- include/pwr_ctrl_pkg.sv ----
// Package for the power unit control register bank: offsets, fields, resets.
// Assumes an 8-bit register port behind the host control serial port.
package pwr_ctrl_pkg;

    // Register request carried from the serial port decoder
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    // Register offsets
    localparam logic [7:0] THIRD_LINEAR_REGULATOR_REGULATOR_CONTROL_OFFSET      = 8'h37;
    localparam logic [7:0] THERMAL_CONTROL_OFFSET             = 8'h38;
    localparam logic [7:0] BACKUP_CHARGER_CONTROL_OFFSET      = 8'h39;
    localparam logic [7:0] STEP_DOWN_CONVERTER_CONTROL_OFFSET = 8'h3e;
    localparam logic [7:0] DEVICE_STATE_CONTROL_OFFSET        = 8'h3f;

    // Field positions
    localparam int VSEL_LSB          = 2;
    localparam int HOT_DIE_FLAG_BIT  = 5;
    localparam int SHUTDOWN_FLAG_BIT = 4;
    localparam int HD_SEL_LSB        = 2;
    localparam int TS_ENABLE_BIT     = 0;
    localparam int BB_VOLT_LSB       = 1;
    localparam int BB_EN_BIT         = 0;
    localparam int TRACK_BIT         = 6;
    localparam int PSKIP_LSB         = 3;
    localparam int EXT_CLK_BIT       = 2;
    localparam int SYNC_MODE_LSB     = 0;
    localparam int SEQ_OFF_BIT       = 7;
    localparam int CAL_PD_BIT        = 6;
    localparam int SLOW_CLK_BIT      = 5;
    localparam int SR_SEL_BIT        = 4;
    localparam int OFF_RST_BIT       = 3;
    localparam int KEEP_ON_BIT       = 2;
    localparam int SLEEP_BIT         = 1;
    localparam int OFF_BIT           = 0;

    // Values after reset
    localparam logic [4:0] VSEL_RESET      = 5'h00;
    localparam logic [1:0] STATE_RESET     = 2'h0;
    localparam logic [1:0] HD_SEL_RESET    = 2'h3;
    localparam logic       TS_ENABLE_RESET = 1'h1;
    localparam logic [1:0] BB_VOLT_RESET   = 2'h0;
    localparam logic       BB_EN_RESET     = 1'h0;
    localparam logic       TRACK_RESET     = 1'h0;
    localparam logic [2:0] PSKIP_RESET     = 3'h7;
    localparam logic       EXT_CLK_RESET   = 1'h0;
    localparam logic [1:0] SYNC_MODE_RESET = 2'h1;
    localparam logic [7:0] DEVCTRL_RESET   = 8'h10;

    // Supply state codes
    localparam logic [1:0] STATE_ACTIVE = 2'h1;
    localparam logic [1:0] STATE_SLEEP  = 2'h3;

    // Voltage map in millivolts
    localparam logic [4:0]  VSEL_FLOOR_CODE = 5'h02;
    localparam logic [4:0]  VSEL_TOP_CODE   = 5'h19;
    localparam logic [11:0] MV_FLOOR        = 12'h3e8;
    localparam logic [11:0] MV_STEP         = 12'h064;
    localparam logic [11:0] MV_TOP          = 12'hce4;

    // Synchroniser depth for pins from the analog side
    localparam int SYNC_STAGES = 2;

endpackage

// ---- hdl/pin_sync.sv ----
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes the level is slow compared with the clock.
`timescale 1ns/1ps
module pin_sync
    import pwr_ctrl_pkg::*;
(
    input  wire logic mclk_i,
    input  wire logic rstn_i,
    input  wire logic pin_i,
    output logic      level_o
);
    logic [SYNC_STAGES-1:0] stage;

    // First stage feeds only the second
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stage <= '0;
        end else begin
            stage <= {stage[SYNC_STAGES-2:0], pin_i};
        end
    end

    assign level_o = stage[SYNC_STAGES-1];
endmodule

// ---- hdl/power_unit_control_registers.sv ----
// Control and status register bank of the power unit.
// Assumes a decoded 8-bit register port and same-clock state machine inputs.
//
// Contract
// - Third regulator select codes 0-2 give 1 V, 3 gives 1.1 V, 25 gives 3.3 V
// - Supply state 00 and 10 off, 01 active, 11 low-power sleep
// - Thermal bit 5 reads 1 while hot-die threshold exceeded
// - Thermal bit 4 reads 1 while shutdown threshold exceeded
// - Hot-die selector bits 3:2, 00 low, 11 high, reset 3
// - Thermal bit 0 enables shutdown module, resets enabled
// - Thermal bits 3:2 general reset; bit 0 turn-off reset
// - Charger voltage bits 2:1 select 3.0, 2.52, 3.15 V or battery
// - Charger bit 0 enables backup charging, reset 0
// - Converter bit 6 makes fourth regulator follow first core converter when active
// - Converter bits 5,4,3 enable pulse skip, each reset 1
// - Converter bit 2 muxes second pad to external sync clock
// - Clock field 00/10 unsynced, 01 phase shifted, 11 synced, reset 1
// - Converter bits 7:3 turn-off reset, bits 2:0 general reset
// - Device bit 7 selects reverse-order sequential power-off
// - Device bit 6 gates and resets calendar domain, kept in backup
// - Device bit 5 picks RC oscillator, else crystal or external clock
// - Writing device bit 3 starts switch-off with core reset, cleared when off
// - Device bit 2 keeps device on unless a switch-off request is set
// - Device bit 1 allows sleep, writing 0 wakes unless bit 3 or 0 is written 1, cleared when off
// - Writing device bit 0 starts switch-off without reset, cleared when off
`timescale 1ns/1ps
module power_unit_control_registers
    import pwr_ctrl_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       rstn_i,
    input  wire logic       general_rst_i,
    input  wire logic       turnoff_rst_i,
    input  wire logic       in_backup_i,
    input  wire logic       device_off_i,
    input  wire logic       core1_active_i,
    input  wire logic       hot_die_pin_i,
    input  wire logic       shutdown_temp_pin_i,
    input  wire reg_req_s   reg_req_i,
    output logic [7:0]      reg_rdata_o,
    output logic [11:0]     third_ldo_millivolt_o,
    output logic            third_ldo_on_o,
    output logic            third_ldo_low_power_o,
    output logic [1:0]      hot_die_threshold_select_o,
    output logic            shutdown_enable_o,
    output logic [1:0]      backup_charge_voltage_o,
    output logic            backup_charge_enable_o,
    output logic            fourth_ldo_tracking_o,
    output logic [2:0]      pulse_skip_o,
    output logic            ext_sync_clock_pad_select_o,
    output logic            clock_sync_enable_o,
    output logic            clock_phase_shift_o,
    output logic            sequential_power_off_o,
    output logic            calendar_domain_power_down_o,
    output logic            slow_clock_rc_select_o,
    output logic            keep_on_o,
    output logic            sleep_allowed_o,
    output logic            switch_off_event_o,
    output logic            core_reset_event_o,
    output logic            wake_event_o
);
    logic [4:0] third_ldo_vsel;
    logic [1:0] supply_state;
    logic [1:0] hot_die_threshold_select;
    logic       shutdown_enable;
    logic [1:0] backup_charge_voltage;
    logic       backup_charge_enable;
    logic       track;
    logic [2:0] pulse_skip;
    logic       ext_sync_clock_pad_select;
    logic [1:0] converter_clock_sync_mode;
    logic [7:0] devctrl;
    logic       hot_die_flag;
    logic       shutdown_temp_flag;

    // Analog comparator outputs cross into the clock domain
    pin_sync u_hot_sync (
        .mclk_i  (mclk_i),
        .rstn_i  (rstn_i),
        .pin_i   (hot_die_pin_i),
        .level_o (hot_die_flag)
    );

    pin_sync u_ts_sync (
        .mclk_i  (mclk_i),
        .rstn_i  (rstn_i),
        .pin_i   (shutdown_temp_pin_i),
        .level_o (shutdown_temp_flag)
    );

    // Address decode
    wire [7:0] w       = reg_req_i.wdata;
    wire       wr_ldo  = reg_req_i.wr && (reg_req_i.addr == THIRD_LINEAR_REGULATOR_REGULATOR_CONTROL_OFFSET);
    wire       wr_th   = reg_req_i.wr && (reg_req_i.addr == THERMAL_CONTROL_OFFSET);
    wire       wr_bb   = reg_req_i.wr && (reg_req_i.addr == BACKUP_CHARGER_CONTROL_OFFSET);
    wire       wr_cv   = reg_req_i.wr
                         && (reg_req_i.addr == STEP_DOWN_CONVERTER_CONTROL_OFFSET);
    wire       wr_dev  = reg_req_i.wr && (reg_req_i.addr == DEVICE_STATE_CONTROL_OFFSET);

    // Read images; reserved positions are constant zero
    wire [7:0] img_ldo  = {1'h0, third_ldo_vsel, supply_state};
    wire [7:0] img_th   = {2'h0, hot_die_flag, shutdown_temp_flag,
                           hot_die_threshold_select, 1'h0, shutdown_enable};
    wire [7:0] img_bb   = {5'h00, backup_charge_voltage, backup_charge_enable};
    wire [7:0] img_cv   = {1'h0, track, pulse_skip, ext_sync_clock_pad_select,
                           converter_clock_sync_mode};
    wire [7:0] img_rd;
    assign img_rd = (reg_req_i.addr == THIRD_LINEAR_REGULATOR_REGULATOR_CONTROL_OFFSET)      ? img_ldo  :
                    (reg_req_i.addr == THERMAL_CONTROL_OFFSET)             ? img_th   :
                    (reg_req_i.addr == BACKUP_CHARGER_CONTROL_OFFSET)      ? img_bb   :
                    (reg_req_i.addr == STEP_DOWN_CONVERTER_CONTROL_OFFSET) ? img_cv   :
                    (reg_req_i.addr == DEVICE_STATE_CONTROL_OFFSET)        ? devctrl  :
                    8'h00;

    // Turn-off reset domain
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            third_ldo_vsel  <= VSEL_RESET;
            supply_state    <= STATE_RESET;
            shutdown_enable <= TS_ENABLE_RESET;
            track           <= TRACK_RESET;
            pulse_skip      <= PSKIP_RESET;
        end else if (turnoff_rst_i) begin
            third_ldo_vsel  <= VSEL_RESET;
            supply_state    <= STATE_RESET;
            shutdown_enable <= TS_ENABLE_RESET;
            track           <= TRACK_RESET;
            pulse_skip      <= PSKIP_RESET;
        end else begin
            if (wr_ldo) begin
                third_ldo_vsel <= w[VSEL_LSB +: 5];
                supply_state   <= w[1:0];
            end
            if (wr_th) begin
                shutdown_enable <= w[TS_ENABLE_BIT];
            end
            if (wr_cv) begin
                track      <= w[TRACK_BIT];
                pulse_skip <= w[PSKIP_LSB +: 3];
            end
        end
    end

    // General reset domain
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hot_die_threshold_select  <= HD_SEL_RESET;
            backup_charge_voltage     <= BB_VOLT_RESET;
            backup_charge_enable      <= BB_EN_RESET;
            ext_sync_clock_pad_select <= EXT_CLK_RESET;
            converter_clock_sync_mode <= SYNC_MODE_RESET;
        end else if (general_rst_i) begin
            hot_die_threshold_select  <= HD_SEL_RESET;
            backup_charge_voltage     <= BB_VOLT_RESET;
            backup_charge_enable      <= BB_EN_RESET;
            ext_sync_clock_pad_select <= EXT_CLK_RESET;
            converter_clock_sync_mode <= SYNC_MODE_RESET;
        end else begin
            if (wr_th) begin
                hot_die_threshold_select <= w[HD_SEL_LSB +: 2];
            end
            if (wr_bb) begin
                backup_charge_voltage <= w[BB_VOLT_LSB +: 2];
                backup_charge_enable  <= w[BB_EN_BIT];
            end
            if (wr_cv) begin
                ext_sync_clock_pad_select <= w[EXT_CLK_BIT];
                converter_clock_sync_mode <= w[SYNC_MODE_LSB +: 2];
            end
        end
    end

    // Device control: a write of 1 wins over the off-state clear
    wire       off_clear = device_off_i || turnoff_rst_i;
    wire [7:0] dev_gen_mask = 8'hf4;
    logic [7:0] next_devctrl;
    always_comb begin
        next_devctrl = devctrl;
        if (general_rst_i) begin
            next_devctrl = (devctrl & ~dev_gen_mask) | (DEVCTRL_RESET & dev_gen_mask);
            // Calendar power-down survives the backup state
            if (in_backup_i) begin
                next_devctrl[CAL_PD_BIT] = devctrl[CAL_PD_BIT];
            end
        end else if (wr_dev) begin
            next_devctrl[7:4]         = w[7:4];
            next_devctrl[KEEP_ON_BIT] = w[KEEP_ON_BIT];
        end
        if (wr_dev) begin
            next_devctrl[OFF_RST_BIT] = w[OFF_RST_BIT];
            next_devctrl[SLEEP_BIT]   = w[SLEEP_BIT];
            next_devctrl[OFF_BIT]     = w[OFF_BIT];
        end else if (off_clear) begin
            next_devctrl[OFF_RST_BIT] = 1'h0;
            next_devctrl[SLEEP_BIT]   = 1'h0;
            next_devctrl[OFF_BIT]     = 1'h0;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            devctrl <= DEVCTRL_RESET;
        end else begin
            devctrl <= next_devctrl;
        end
    end

    // Millivolt figure, saturating above the top code
    function automatic logic [11:0] vsel_to_mv(input logic [4:0] code);
        logic [11:0] steps;
        steps = {7'h00, code} - {7'h00, VSEL_FLOOR_CODE};
        if (code <= VSEL_FLOOR_CODE) begin
            vsel_to_mv = MV_FLOOR;
        end else if (code >= VSEL_TOP_CODE) begin
            vsel_to_mv = MV_TOP;
        end else begin
            vsel_to_mv = MV_FLOOR + 12'(steps * MV_STEP);
        end
    endfunction

    wire devoff_block = devctrl[OFF_BIT] || devctrl[OFF_RST_BIT];
    wire wake_write   = wr_dev && !w[SLEEP_BIT] && !w[OFF_BIT] && !w[OFF_RST_BIT];

    // Outputs from flops
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_o                  <= 8'h00;
            third_ldo_millivolt_o        <= MV_FLOOR;
            third_ldo_on_o               <= 1'h0;
            third_ldo_low_power_o        <= 1'h0;
            hot_die_threshold_select_o   <= HD_SEL_RESET;
            shutdown_enable_o            <= TS_ENABLE_RESET;
            backup_charge_voltage_o      <= BB_VOLT_RESET;
            backup_charge_enable_o       <= BB_EN_RESET;
            fourth_ldo_tracking_o        <= 1'h0;
            pulse_skip_o                 <= PSKIP_RESET;
            ext_sync_clock_pad_select_o  <= EXT_CLK_RESET;
            clock_sync_enable_o          <= 1'h1;
            clock_phase_shift_o          <= 1'h1;
            sequential_power_off_o       <= 1'h0;
            calendar_domain_power_down_o <= 1'h0;
            slow_clock_rc_select_o       <= 1'h0;
            keep_on_o                    <= 1'h0;
            sleep_allowed_o              <= 1'h0;
            switch_off_event_o           <= 1'h0;
            core_reset_event_o           <= 1'h0;
            wake_event_o                 <= 1'h0;
        end else begin
            reg_rdata_o      <= reg_req_i.rd ? img_rd : 8'h00;
            third_ldo_millivolt_o <= vsel_to_mv(third_ldo_vsel);
            third_ldo_on_o        <= supply_state[0];
            third_ldo_low_power_o <= (supply_state == STATE_SLEEP);
            hot_die_threshold_select_o  <= hot_die_threshold_select;
            shutdown_enable_o           <= shutdown_enable;
            backup_charge_voltage_o     <= backup_charge_voltage;
            backup_charge_enable_o      <= backup_charge_enable;
            fourth_ldo_tracking_o       <= track && core1_active_i;
            pulse_skip_o                <= pulse_skip;
            ext_sync_clock_pad_select_o <= ext_sync_clock_pad_select;
            clock_sync_enable_o         <= converter_clock_sync_mode[0];
            clock_phase_shift_o         <= (converter_clock_sync_mode == 2'h1);
            sequential_power_off_o      <= devctrl[SEQ_OFF_BIT];
            calendar_domain_power_down_o <= devctrl[CAL_PD_BIT];
            slow_clock_rc_select_o      <= devctrl[SLOW_CLK_BIT];
            keep_on_o        <= devctrl[KEEP_ON_BIT] && !devoff_block;
            sleep_allowed_o  <= devctrl[SLEEP_BIT] && !devoff_block;
            switch_off_event_o <= wr_dev && (w[OFF_BIT] || w[OFF_RST_BIT]);
            core_reset_event_o <= wr_dev && w[OFF_RST_BIT];
            wake_event_o       <= wake_write;
        end
    end

    // Checks
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    sequence thermal_read_s;
        reg_req_i.rd && (reg_req_i.addr == THERMAL_CONTROL_OFFSET);
    endsequence

    sequence hot_steady_s;
        hot_die_pin_i [*3];
    endsequence

    sequence ts_steady_s;
        shutdown_temp_pin_i [*3];
    endsequence

    volt_step_check_a: assert property (
        (third_ldo_vsel == 5'h03) |=> (third_ldo_millivolt_o == 12'h44c))
        else $error("Select code 3 did not give 1.1 V");

    supply_off_check_a: assert property (
        (supply_state == 2'h2) |=> (!third_ldo_on_o && !third_ldo_low_power_o))
        else $error("State 10 did not switch the regulator off");

    hot_flag_read_a: assert property (
        (hot_steady_s ##0 thermal_read_s) |=> reg_rdata_o[HOT_DIE_FLAG_BIT])
        else $error("Hot-die flag not seen on read");

    ts_flag_read_a: assert property (
        (ts_steady_s ##0 thermal_read_s) |=> reg_rdata_o[SHUTDOWN_FLAG_BIT])
        else $error("Shutdown flag not seen on read");

    hdsel_reset_a: assert property (
        general_rst_i |=> (hot_die_threshold_select == HD_SEL_RESET) ##1
                          (hot_die_threshold_select_o == HD_SEL_RESET))
        else $error("Hot-die selector not restored by general reset");

    ts_enable_reset_a: assert property (
        turnoff_rst_i |=> shutdown_enable ##1 shutdown_enable_o)
        else $error("Shutdown enable not restored by turn-off reset");

    track_follow_a: assert property (
        (track && core1_active_i) |=> fourth_ldo_tracking_o)
        else $error("Fourth regulator not tracking");

    off_clear_a: assert property (
        (device_off_i && !wr_dev) |=> (devctrl[2'h3] == 1'h0) && !devctrl[1] && !devctrl[0])
        else $error("Switch-off requests not cleared in off state");

    keep_on_block_a: assert property (
        devoff_block |=> !keep_on_o)
        else $error("Keep-on active during switch-off request");

    off_pulse_a: assert property (
        (wr_dev && w[OFF_BIT]) |=> switch_off_event_o && devctrl[OFF_BIT])
        else $error("Switch-off write gave no event");

    reserved_zero_a: assert property (
        thermal_read_s |=> (reg_rdata_o[7:6] == 2'h0) && !reg_rdata_o[1])
        else $error("Reserved thermal bits read nonzero");
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the power unit control register bank.
// Assumes the bank is reached through the decoded one-cycle request port.
`timescale 1ns/1ps
module testbench;
    import pwr_ctrl_pkg::*;
    logic        mclk_i = 0, rstn_i = 0, general_rst_i = 0, turnoff_rst_i = 0;
    logic        in_backup_i = 0, device_off_i = 0, core1_active_i = 0;
    logic        hot_die_pin_i = 0, shutdown_temp_pin_i = 0;
    reg_req_s    reg_req_i = '0;
    logic [7:0]  reg_rdata_o;
    logic [11:0] third_ldo_millivolt_o;
    logic [1:0]  hot_die_threshold_select_o, backup_charge_voltage_o;
    logic [2:0]  pulse_skip_o;
    logic        third_ldo_on_o, third_ldo_low_power_o, shutdown_enable_o, backup_charge_enable_o;
    logic        fourth_ldo_tracking_o, ext_sync_clock_pad_select_o, clock_sync_enable_o;
    logic        clock_phase_shift_o, sequential_power_off_o, calendar_domain_power_down_o;
    logic        slow_clock_rc_select_o, keep_on_o, sleep_allowed_o;
    logic        switch_off_event_o, core_reset_event_o, wake_event_o;
    int          bad_count = 0, checks_done = 0;
    logic [7:0]  exp_q[$];
    logic [7:0]  shadow[5];
    logic [2:0]  ev;
    logic        rd_seen = 0;
    logic [7:0]  a, d;
    logic [11:0] mv;
    localparam logic [7:0] ADDRS[6] = '{8'h37, 8'h38, 8'h39, 8'h3e, 8'h3f, 8'h3a};
    localparam logic [7:0] DEV[6] = '{8'h06, 8'h01, 8'h00, 8'h08, 8'h02, 8'he4};
    localparam logic [4:0] CODES[7] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h18, 5'h19, 5'h0a};

    power_unit_control_registers uut (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .general_rst_i(general_rst_i),
        .turnoff_rst_i(turnoff_rst_i), .in_backup_i(in_backup_i),
        .device_off_i(device_off_i), .core1_active_i(core1_active_i),
        .hot_die_pin_i(hot_die_pin_i), .shutdown_temp_pin_i(shutdown_temp_pin_i),
        .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
        .third_ldo_millivolt_o(third_ldo_millivolt_o),
        .third_ldo_on_o(third_ldo_on_o), .third_ldo_low_power_o(third_ldo_low_power_o),
        .hot_die_threshold_select_o(hot_die_threshold_select_o),
        .shutdown_enable_o(shutdown_enable_o), .backup_charge_voltage_o(backup_charge_voltage_o),
        .backup_charge_enable_o(backup_charge_enable_o),
        .fourth_ldo_tracking_o(fourth_ldo_tracking_o),
        .pulse_skip_o(pulse_skip_o), .ext_sync_clock_pad_select_o(ext_sync_clock_pad_select_o),
        .clock_sync_enable_o(clock_sync_enable_o), .clock_phase_shift_o(clock_phase_shift_o),
        .sequential_power_off_o(sequential_power_off_o),
        .calendar_domain_power_down_o(calendar_domain_power_down_o),
        .slow_clock_rc_select_o(slow_clock_rc_select_o), .keep_on_o(keep_on_o),
        .sleep_allowed_o(sleep_allowed_o), .switch_off_event_o(switch_off_event_o),
        .core_reset_event_o(core_reset_event_o), .wake_event_o(wake_event_o)
    );

    initial begin
        forever #12.5 mclk_i = ~mclk_i;
    end

    function automatic int idx(logic [7:0] ad);
        for (int i = 0; i < 5; i++) begin
            if (ADDRS[i] == ad) return i;
        end
        return 5;
    endfunction

    function automatic logic [7:0] rw_mask(int i);
        logic [7:0] m[5] = '{8'h7f, 8'h0d, 8'h07, 8'h7f, 8'hff};
        return m[i];
    endfunction

    // Flags are live levels, so the expected read folds in the current pins
    function automatic logic [7:0] exp_read(logic [7:0] ad);
        int i;
        i = idx(ad);
        if (i == 5) return 8'h00;
        if (i == 1) return shadow[1] | {2'h0, hot_die_pin_i, shutdown_temp_pin_i, 4'h0};
        return shadow[i];
    endfunction

    task automatic check(logic [11:0] seen, logic [11:0] expv);
        checks_done++;
        if (seen !== expv) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, expv);
        end
    endtask

    task automatic tick;
        @(posedge mclk_i);
        #1;
    endtask

    // Read data is noted before the write lands, as a same-cycle read sees the old value
    task automatic access(logic w, logic r, logic [7:0] ad, logic [7:0] dv);
        tick;
        reg_req_i = '{wr: w, rd: r, addr: ad, wdata: dv};
        if (r) exp_q.push_back(exp_read(ad));
        if (w && idx(ad) < 5) shadow[idx(ad)] = dv & rw_mask(idx(ad));
        tick;
        ev = {switch_off_event_o, core_reset_event_o, wake_event_o};
        reg_req_i = '0;
    endtask

    task automatic read_all;
        for (int i = 0; i < 6; i++) access(0, 1, ADDRS[i], 8'h00);
    endtask

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    always @(posedge mclk_i) rd_seen <= reg_req_i.rd;

    always @(negedge mclk_i) begin
        if (rd_seen) begin
            if (exp_q.size() == 0) check(12'hfff, 12'h000);
            else check(reg_rdata_o, exp_q.pop_front());
        end
    end

    initial begin
        repeat (20000) @(posedge mclk_i);
        bad_count++;
        conclude;
    end

    initial begin
        void'($urandom(50));
        shadow = '{8'h00, 8'h0d, 8'h00, 8'h39, 8'h10};
        repeat (16) @(posedge mclk_i);
        #1;
        rstn_i = 1;
        check(third_ldo_millivolt_o, 12'h3e8);
        check({hot_die_threshold_select_o, shutdown_enable_o}, 3'h7);
        check({pulse_skip_o, clock_sync_enable_o, clock_phase_shift_o}, 5'h1f);
        check({backup_charge_voltage_o, backup_charge_enable_o}, 3'h0);
        read_all;
        // Reserved and read-only bits must not take the all-ones pattern
        for (int i = 0; i < 4; i++) access(1, 1, ADDRS[i], 8'hff);
        read_all;
        for (int i = 0; i < 7; i++) begin
            d = {1'h0, CODES[i], i[1:0]};
            access(1, 0, 8'h37, d);
            tick;
            tick;
            mv = (CODES[i] <= 5'h02) ? 12'h3e8 : (CODES[i] >= 5'h19) ? 12'hce4 :
                 12'h3e8 + 12'h064 * (12'(CODES[i]) - 12'h002);
            check(third_ldo_millivolt_o, mv);
            check({third_ldo_on_o, third_ldo_low_power_o}, {d[0], d[1:0] == 2'h3});
        end
        hot_die_pin_i = 1;
        repeat (3) tick;
        access(1, 1, 8'h38, 8'h00);
        shutdown_temp_pin_i = 1;
        hot_die_pin_i = 0;
        repeat (3) tick;
        check({hot_die_threshold_select_o, shutdown_enable_o}, 3'h0);
        access(0, 1, 8'h38, 8'h00);
        shutdown_temp_pin_i = 0;
        repeat (3) tick;
        for (int v = 0; v < 4; v++) begin
            access(1, 0, 8'h39, {5'h0, v[1:0], v[0]});
            access(1, 0, 8'h3e, {1'h0, v[0], v[2:0] ^ 3'h5, v[1], v[1:0]});
            core1_active_i = v[1];
            tick;
            tick;
            check({backup_charge_voltage_o, backup_charge_enable_o}, {v[1:0], v[0]});
            check({clock_sync_enable_o, clock_phase_shift_o}, {v[0], v[1:0] == 2'h1});
            check({pulse_skip_o, ext_sync_clock_pad_select_o}, {v[2:0] ^ 3'h5, v[1]});
            check(fourth_ldo_tracking_o, v[0] & v[1]);
        end
        for (int i = 0; i < 6; i++) begin
            access(1, 0, 8'h3f, DEV[i]);
            d = DEV[i];
            check(ev, {d[0] | d[3], d[3], ~(d[0] | d[1] | d[3])});
            tick;
            tick;
            check({sequential_power_off_o, calendar_domain_power_down_o,
                   slow_clock_rc_select_o}, d[7:5]);
            check({keep_on_o, sleep_allowed_o}, d[2:1] & {2{~(d[0] | d[3])}});
            device_off_i = 1;
            tick;
            device_off_i = 0;
            shadow[4] = shadow[4] & 8'hf4;
            access(0, 1, 8'h3f, 8'h00);
        end
        access(1, 0, 8'h3f, 8'hef);
        access(1, 0, 8'h3e, 8'h7e);
        in_backup_i = 1;
        general_rst_i = 1;
        tick;
        general_rst_i = 0;
        in_backup_i = 0;
        shadow[1] = (shadow[1] & 8'h01) | 8'h0c;
        shadow[2] = 8'h00;
        shadow[3] = (shadow[3] & 8'hf8) | 8'h01;
        shadow[4] = (shadow[4] & 8'h4b) | 8'h10;
        read_all;
        turnoff_rst_i = 1;
        tick;
        turnoff_rst_i = 0;
        shadow[0] = 8'h00;
        shadow[1] = shadow[1] | 8'h01;
        shadow[3] = (shadow[3] & 8'h07) | 8'h38;
        shadow[4] = shadow[4] & 8'hf4;
        read_all;
        // Outside the backup state a general reset must also clear calendar power-down
        general_rst_i = 1;
        tick;
        general_rst_i = 0;
        shadow[4] = 8'h10;
        access(0, 1, 8'h3f, 8'h00);
        for (int i = 0; i < 12; i++) begin
            a = ADDRS[$urandom % 6];
            access(1, $urandom % 2, a, 8'($urandom));
            access(0, 1, a, 8'h00);
        end
        repeat (3) tick;
        conclude;
    end
endmodule
